// File: rtl/mdb_pkg.sv
// Package of register map, field positions and types for the digital block
package mdb_pkg;
   localparam logic [7:0] ADDR_COUNT = 8'h20;
   localparam logic [7:0] ADDR_PERIOD = 8'h21;
   localparam logic [7:0] ADDR_COMPARE = 8'h22;
   localparam logic [7:0] ADDR_CONTROL = 8'h23;
   localparam logic [7:0] ADDR_FUNCTION = 8'h24;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h25;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h26;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [2:0] FN_TIMER = 3'h0;
   localparam logic [2:0] FN_COUNTER = 3'h1;
   localparam logic [2:0] FN_CYCLIC_CHECK_PSEUDORANDOM_GEN = 3'h2;
   localparam logic [2:0] FN_DUALPWM = 3'h3;
   localparam logic [2:0] FN_DEADBAND = 3'h4;
   localparam logic [2:0] FN_MODULATOR = 3'h7;
   localparam logic [2:0] FN_SERIAL = 3'h6;
   localparam logic [2:0] FN_RECEIVE = 3'h5;
   localparam int CTL_ENABLE = 0;
   localparam int CTL_BIT1 = 1;
   localparam int CTL_BIT2 = 2;
   localparam int CTL_NPS = 3;
   localparam int CTL_KILL_LSB = 4;
   localparam int FN_MODE0 = 3;
   localparam int DEAD_TIME_CYCLES = 1;
   localparam int IRQ_TC = 0;
   localparam int IRQ_CAPTURE = 1;
   localparam int IRQ_BLOCK = 2;
   localparam int IRQ_KILL = 3;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } mdb_bus_s;
   typedef struct packed {
      logic primary;
      logic auxiliary;
      logic block_irq;
   } mdb_out_s;
endpackage

// File: rtl/mdb_block.sv
// Configurable 8-bit digital block: timer, counter, dead band, CRC/PRS
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module mdb_block (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic block_clk_pin,
   input wire logic data_in_pin,
   input wire logic capture_pin,
   input wire logic prev_primary_pin,
   input wire logic [15:0] kill_sources,
   output logic primary_out,
   output logic auxiliary_out,
   output logic phase_one_output,
   output logic phase_two_output,
   output logic block_irq,
   output logic irq
);
   // Pin synchronisers: first stage read only by second
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic [15:0] kill1_reg;
   logic [15:0] kill2_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
         kill1_reg <= 16'h0000;
         kill2_reg <= 16'h0000;
      end else begin
         sync1_reg <= {prev_primary_pin, capture_pin, data_in_pin,
            block_clk_pin};
         sync2_reg <= sync1_reg;
         kill1_reg <= kill_sources;
         kill2_reg <= kill1_reg;
      end
   end
   wire bclk = sync2_reg[0];
   wire din = sync2_reg[1];
   wire cap_in = sync2_reg[2];
   wire prev_in = sync2_reg[3];

   // Block clock edges become one-cycle enables
   logic bclk_d_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         bclk_d_reg <= 1'b0;
      end else begin
         bclk_d_reg <= bclk;
      end
   end
   wire bclk_rise = bclk & ~bclk_d_reg;
   wire bclk_fall = ~bclk & bclk_d_reg;

   // Registers
   logic [7:0] count_reg;
   logic [7:0] period_reg;
   logic [7:0] compare_reg;
   logic [7:0] compare_buf_reg;
   logic buf_pending_reg;
   logic [7:0] control_reg;
   logic [7:0] function_reg;
   logic [3:0] irq_status_reg;
   logic [3:0] irq_mask_reg;
   logic [7:0] rdata_reg;

   wire [2:0] fn = function_reg[2:0];
   wire is_timer = (fn == mdb_pkg::FN_TIMER);
   wire is_counter = (fn == mdb_pkg::FN_COUNTER);
   wire is_crc = (fn == mdb_pkg::FN_CYCLIC_CHECK_PSEUDORANDOM_GEN);
   wire is_dead = (fn == mdb_pkg::FN_DEADBAND);
   wire counts_mode = is_timer | is_counter | is_dead
      | (fn == mdb_pkg::FN_DUALPWM) | (fn == mdb_pkg::FN_MODULATOR);
   wire compare_ro = (fn == mdb_pkg::FN_SERIAL)
      | (fn == mdb_pkg::FN_RECEIVE);
   wire enable = control_reg[mdb_pkg::CTL_ENABLE];
   wire ctl1 = control_reg[mdb_pkg::CTL_BIT1];
   wire ctl2 = control_reg[mdb_pkg::CTL_BIT2];
   wire negative_phase_select = control_reg[mdb_pkg::CTL_NPS];
   wire [3:0] kill_sel = control_reg[7:mdb_pkg::CTL_KILL_LSB];
   wire kill_used = is_timer | is_counter | is_crc;
   wire kill = kill_used & kill2_reg[kill_sel];

   wire wr_period = wr & (addr == mdb_pkg::ADDR_PERIOD);
   wire wr_compare = wr & (addr == mdb_pkg::ADDR_COMPARE) & ~compare_ro;
   wire wr_control = wr & (addr == mdb_pkg::ADDR_CONTROL);
   wire wr_function = wr & (addr == mdb_pkg::ADDR_FUNCTION);
   wire wr_mask = wr & (addr == mdb_pkg::ADDR_IRQ_MASK);
   wire rd_count = rd & (addr == mdb_pkg::ADDR_COUNT);
   wire rd_status = rd & (addr == mdb_pkg::ADDR_IRQ_STATUS);

   // Counter engine; counter gated by data input as count enable
   wire run = enable & ~kill & (counts_mode | is_crc);
   wire step = run & bclk_rise & (~is_counter | din);
   wire at_tc = (count_reg == 8'h00);
   wire tc_event = step & at_tc & ~is_crc;
   // Period zero reloads every clock, so the narrow pulse still toggles
   wire [7:0] count_dec = count_reg - 8'h01;

   // CRC/PRS: shift mode kills feedback
   wire [7:0] feedback = ctl2 ? 8'h00 : period_reg;
   wire lfsr_msb = count_reg[7] ^ (is_crc & din);
   wire [7:0] lfsr_next = {count_reg[6:0], 1'b0}
      ^ (lfsr_msb ? feedback : 8'h00);

   logic [7:0] count_next;
   always_comb begin
      count_next = count_reg;
      if (is_crc & step) begin
         count_next = lfsr_next;
      end else if (step) begin
         count_next = at_tc ? period_reg : count_dec;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count_reg <= mdb_pkg::RESET_BYTE;
         period_reg <= mdb_pkg::RESET_BYTE;
         control_reg <= mdb_pkg::RESET_BYTE;
         function_reg <= mdb_pkg::RESET_BYTE;
         irq_mask_reg <= 4'h0;
      end else begin
         count_reg <= count_next;
         if (wr_period) begin
            period_reg <= wdata;
         end
         if (wr_control) begin
            control_reg <= wdata;
         end
         if (wr_function) begin
            function_reg <= wdata;
         end
         if (wr_mask) begin
            irq_mask_reg <= wdata[3:0];
         end
      end
   end

   // Compare register: buffered update, capture, count snapshot
   wire buffered = is_counter & ctl1 & enable;
   wire capture_now = is_timer & enable & cap_in;
   always_ff @(posedge clk) begin
      if (rst) begin
         compare_reg <= mdb_pkg::RESET_BYTE;
         compare_buf_reg <= mdb_pkg::RESET_BYTE;
         buf_pending_reg <= 1'b0;
      end else begin
         if (rd_count & counts_mode) begin
            compare_reg <= count_reg;
         end else if (capture_now) begin
            compare_reg <= count_reg;
         end else if (wr_compare & ~buffered) begin
            compare_reg <= wdata;
         end else if (buf_pending_reg & tc_event) begin
            compare_reg <= compare_buf_reg;
         end
         if (wr_compare & buffered) begin
            compare_buf_reg <= wdata;
            buf_pending_reg <= 1'b1;
         end else if (tc_event | ~buffered) begin
            buf_pending_reg <= 1'b0;
         end
      end
   end

   // Compare output; negative phase holds updates while clock high
   logic cmp_reg;
   wire cmp_value = (count_reg <= compare_reg);
   wire cmp_ok = ~negative_phase_select | ~bclk;
   always_ff @(posedge clk) begin
      if (rst) begin
         cmp_reg <= 1'b0;
      end else if (cmp_ok) begin
         cmp_reg <= cmp_value & run;
      end
   end

   // Terminal count pulse: narrow ends on falling edge, wide on next rise
   logic tc_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         tc_reg <= 1'b0;
      end else if (tc_event & is_timer | tc_event & is_counter) begin
         tc_reg <= 1'b1;
      end else if (~ctl2 & bclk_fall) begin
         tc_reg <= 1'b0;
      end else if (ctl2 & bclk_rise) begin
         tc_reg <= 1'b0;
      end
   end
   wire tc_wide = is_timer & ctl2;
   wire tc_pulse = tc_reg & (tc_wide | is_counter | ~ctl2);

   // Dead band generator
   wire dead_ref = ctl1 ? ctl2 : prev_in;
   logic ref_d_reg;
   logic [7:0] dead_cnt_reg;
   logic ph1_reg;
   logic ph2_reg;
   wire dead_on = is_dead & enable & ~kill;
   wire ref_change = dead_on & (dead_ref != ref_d_reg);
   wire dead_done = (dead_cnt_reg == 8'h00);
   always_ff @(posedge clk) begin
      if (rst) begin
         ref_d_reg <= 1'b0;
         dead_cnt_reg <= 8'h00;
         ph1_reg <= 1'b0;
         ph2_reg <= 1'b0;
      end else if (~dead_on) begin
         ref_d_reg <= dead_ref;
         dead_cnt_reg <= 8'h00;
         ph1_reg <= 1'b0;
         ph2_reg <= 1'b0;
      end else if (ref_change) begin
         ref_d_reg <= dead_ref;
         dead_cnt_reg <= period_reg;
         ph1_reg <= 1'b0;
         ph2_reg <= 1'b0;
      end else if (~dead_done & bclk_rise) begin
         dead_cnt_reg <= dead_cnt_reg - 8'h01;
      end else if (dead_done) begin
         ph1_reg <= ref_d_reg;
         ph2_reg <= ~ref_d_reg;
      end
   end

   // Output selection per function
   wire pass = is_crc & ctl1;
   wire crc_primary = count_reg[7] & enable;
   logic primary_next;
   logic aux_next;
   always_comb begin
      primary_next = 1'b0;
      aux_next = 1'b0;
      if (pass) begin
         primary_next = din;
         aux_next = bclk;
      end else if (is_crc) begin
         primary_next = crc_primary;
      end else if (is_timer | is_counter) begin
         primary_next = cmp_reg;
         aux_next = tc_pulse;
      end else if (is_dead) begin
         primary_next = ph1_reg;
         aux_next = ph2_reg;
      end
   end

   // Block interrupt source
   wire mode0 = function_reg[mdb_pkg::FN_MODE0];
   logic blk_irq_next;
   always_comb begin
      blk_irq_next = 1'b0;
      if (pass) begin
         blk_irq_next = din;
      end else if (is_timer & ctl1) begin
         blk_irq_next = capture_now;
      end else if (is_timer) begin
         blk_irq_next = mode0 ? cmp_reg : tc_pulse;
      end else if (is_counter) begin
         blk_irq_next = mode0 ? cmp_reg : tc_pulse;
      end else if (is_crc) begin
         blk_irq_next = crc_primary;
      end
   end

   logic blk_irq_d_reg;
   mdb_pkg::mdb_out_s out_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         out_reg <= '0;
         blk_irq_d_reg <= 1'b0;
      end else begin
         out_reg <= '{primary: primary_next, auxiliary: aux_next,
            block_irq: blk_irq_next};
         blk_irq_d_reg <= out_reg.block_irq;
      end
   end

   // Sticky status; set wins over read clear
   // Kill is seen while enabled; run already masks it, so it cannot serve
   wire [3:0] irq_events = {kill & enable,
      out_reg.block_irq & ~blk_irq_d_reg,
      capture_now, tc_event};
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_status_reg <= 4'h0;
      end else begin
         irq_status_reg <= (rd_status ? 4'h0 : irq_status_reg) | irq_events;
      end
   end

   // Read mux; period register reads zero as it is write-only
   logic [7:0] rdata_next;
   always_comb begin
      rdata_next = 8'h00;
      unique case (addr)
         mdb_pkg::ADDR_COMPARE: rdata_next = compare_reg;
         mdb_pkg::ADDR_CONTROL: rdata_next = control_reg;
         mdb_pkg::ADDR_FUNCTION: rdata_next = function_reg;
         mdb_pkg::ADDR_IRQ_STATUS: rdata_next = {4'h0, irq_status_reg};
         mdb_pkg::ADDR_IRQ_MASK: rdata_next = {4'h0, irq_mask_reg};
         default: rdata_next = 8'h00;
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rd ? rdata_next : 8'h00;
      end
   end

   assign rdata = rdata_reg;
   assign primary_out = out_reg.primary;
   assign auxiliary_out = out_reg.auxiliary;
   assign block_irq = out_reg.block_irq;
   assign phase_one_output = ph1_reg;
   assign phase_two_output = ph2_reg;
   assign irq = |(irq_status_reg & irq_mask_reg);
endmodule // mdb_block
`default_nettype wire

// File: tb/mdb_block_assertions.sv
// Checker of register reads and pin relations of the digital block
`timescale 1ns/100ps
`default_nettype none
module mdb_block_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic block_clk_pin,
   input wire logic data_in_pin,
   input wire logic primary_out,
   input wire logic auxiliary_out,
   input wire logic phase_one_output,
   input wire logic phase_two_output,
   input wire logic block_irq,
   input wire logic irq
);
   logic [7:0] ctl_q, fn_q, mask_q;
   logic [2:0] age_q;
   wire ctl_wr = wr && addr == 8'h23;
   wire fn_wr = wr && addr == 8'h24;
   // Pass checks wait out the pin synchronisers after a mode change
   wire pass_on = fn_q[2:0] == 3'h2 && ctl_q[1:0] == 2'h3 && age_q == 3'h7;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_q <= 8'h00;
         fn_q <= 8'h00;
         mask_q <= 8'h00;
         age_q <= 3'h0;
      end else begin
         if (ctl_wr) ctl_q <= wdata;
         if (fn_wr) fn_q <= wdata;
         if (wr && addr == 8'h26) mask_q <= wdata;
         if (ctl_wr || fn_wr) age_q <= 3'h0;
         else if (age_q != 3'h7) age_q <= age_q + 3'h1;
      end
   end
   a_rdata_idle_zero: assert property (
      !$past(rd) |-> rdata == 8'h00) else $error("read data outside slot");
   a_period_reads_zero: assert property (
      rd && addr == 8'h21 |=> rdata == 8'h00) else $error("period readable");
   a_count_reads_zero: assert property (
      rd && addr == 8'h20 |=> rdata == 8'h00) else $error("count not zero");
   a_unmapped_reads_zero: assert property (
      rd && (addr < 8'h20 || addr > 8'h26) |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_control_readback: assert property (
      ctl_wr ##2 (rd && addr == 8'h23) |=> rdata == $past(wdata, 3))
      else $error("control readback wrong");
   a_pass_primary: assert property (
      pass_on |-> primary_out == $past(data_in_pin, 3))
      else $error("pass data not on primary");
   a_pass_irq: assert property (
      pass_on |-> block_irq == $past(data_in_pin, 3))
      else $error("pass data not on block irq");
   a_pass_aux: assert property (
      pass_on |-> auxiliary_out == $past(block_clk_pin, 3))
      else $error("pass clock not on auxiliary");
   a_phases_apart: assert property (
      !(phase_one_output && phase_two_output)) else $error("phases overlap");
   a_irq_masked_off: assert property (
      mask_q == 8'h00 |-> !irq) else $error("irq with all masked");
   c_pass_mode: cover property (pass_on && primary_out);
   c_dead_band: cover property ($rose(phase_one_output));
   c_irq_raised: cover property ($rose(irq));
endmodule // mdb_block_checker
bind mdb_block mdb_block_checker i_checker (.clk(clk), .rst(rst),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .block_clk_pin(block_clk_pin), .data_in_pin(data_in_pin),
   .primary_out(primary_out), .auxiliary_out(auxiliary_out),
   .phase_one_output(phase_one_output), .phase_two_output(phase_two_output),
   .block_irq(block_irq), .irq(irq));
`default_nettype wire

// File: tb/mdb_block_tb_top.sv
// Self-checking bench for the digital block registers and pins
`timescale 1ns/100ps
`default_nettype none
module mdb_block_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   mdb_pkg::mdb_bus_s bus = '0;
   logic bclk = 1'b0;
   logic din = 1'b0;
   logic cap = 1'b0;
   logic prev = 1'b0;
   logic [15:0] kill = 16'h0000;
   logic [7:0] rdata, rv;
   logic [7:0] run = 8'h00;
   logic [7:0] last_run = 8'h00;
   logic pri, aux, ph1, ph2, birq, irq;
   logic [10:0] lay [4] = '{11'h0AE, 11'h15A, 11'h236, 11'h406};
   int n_mismatch = 0;
   int tests_run = 0;
   always #2.5 clk = ~clk;
   mdb_block i_dut (.clk(clk), .rst(rst), .addr(bus.addr),
      .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(rdata),
      .block_clk_pin(bclk), .data_in_pin(din), .capture_pin(cap),
      .prev_primary_pin(prev), .kill_sources(kill), .primary_out(pri),
      .auxiliary_out(aux), .phase_one_output(ph1),
      .phase_two_output(ph2), .block_irq(birq), .irq(irq));
   // Length of the last finished high stretch of the auxiliary output
   always @(posedge clk) begin
      if (aux) run <= run + 8'h01;
      else begin
         if (run != 8'h00) last_run <= run;
         run <= 8'h00;
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // An idle cycle follows every access, so strobes never merge
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus <= '0;
      @(posedge clk);
   endtask
   task automatic rd_reg(input logic [7:0] a);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus <= '0;
      #1 rv = rdata;
      @(posedge clk);
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
      rd_reg(a);
      check(rv, exp);
   endtask
   task automatic bc_cycles(input int n);
      repeat (n) begin
         bclk <= 1'b1;
         repeat (4) @(posedge clk);
         bclk <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int a = 'h20; a < 'h27; a++) chk_reg(a[7:0], 8'h00);
      chk_reg(8'h80, 8'h00);
      foreach (lay[i]) begin
         wr_reg(8'h24, {5'h00, lay[i][10:8]});
         wr_reg(8'h23, lay[i][7:0]);
         chk_reg(8'h23, lay[i][7:0]);
      end
      wr_reg(8'h23, 8'h00);
      wr_reg(8'h24, 8'h00);
      wr_reg(8'h21, 8'h10);
      chk_reg(8'h21, 8'h00);
      wr_reg(8'h22, 8'h5A);
      chk_reg(8'h22, 8'h5A);
      for (int f = 5; f < 7; f++) begin
         wr_reg(8'h24, f[7:0]);
         wr_reg(8'h22, 8'hA5);
         chk_reg(8'h22, 8'h5A);
      end
      wr_reg(8'h24, 8'h01);
      wr_reg(8'h23, 8'h01);
      din <= 1'b1;
      bc_cycles(3);
      chk_reg(8'h20, 8'h00);
      wr_reg(8'h23, 8'h00);
      din <= 1'b0;
      rd_reg(8'h22);
      check(rv, 8'h0E);
      // Buffered compare write waits for the next terminal count
      wr_reg(8'h23, 8'h03);
      din <= 1'b1;
      wr_reg(8'h22, 8'h33);
      chk_reg(8'h22, 8'h0E);
      bc_cycles(15);
      chk_reg(8'h22, 8'h33);
      wr_reg(8'h23, 8'h00);
      din <= 1'b0;
      wr_reg(8'h24, 8'h00);
      for (int w = 0; w < 2; w++) begin
         wr_reg(8'h21, w[7:0]);
         wr_reg(8'h23, w ? 8'h05 : 8'h01);
         // First pass starts the count at the period left by the counter run, the second at the zero left by the first pass
         bc_cycles(20);
         wr_reg(8'h23, 8'h00);
         check(last_run, w ? 8'h08 : 8'h04);
      end
      #1 check({7'h00, irq}, 8'h00);
      wr_reg(8'h26, 8'h01);
      #1 check({7'h00, irq}, 8'h01);
      rd_reg(8'h25);
      check(rv & 8'h05, 8'h05);
      #1 check({7'h00, irq}, 8'h00);
      wr_reg(8'h26, 8'h00);
      wr_reg(8'h21, 8'hFF);
      for (int c = 0; c < 2; c++) begin
         rd_reg(8'h25);
         wr_reg(8'h23, c ? 8'h03 : 8'h01);
         cap <= 1'b1;
         repeat (6) @(posedge clk);
         cap <= 1'b0;
         wr_reg(8'h23, 8'h00);
         chk_reg(8'h25, c ? 8'h06 : 8'h02);
      end
      for (int s = 0; s < 16; s++) begin
         wr_reg(8'h23, {s[3:0], 4'h1});
         for (int k = 1; k >= 0; k--) begin
            rd_reg(8'h25);
            kill <= 16'h0001 << ((s + k) % 16);
            repeat (5) @(posedge clk);
            kill <= 16'h0000;
            rd_reg(8'h25);
            check(rv & 8'h08, k ? 8'h00 : 8'h08);
         end
         wr_reg(8'h23, 8'h00);
      end
      wr_reg(8'h24, 8'h02);
      wr_reg(8'h23, 8'h03);
      for (int v = 0; v < 4; v++) begin
         din <= v[0];
         bclk <= v[1];
         repeat (5) @(posedge clk);
         #1 check({5'h00, aux, birq, pri}, {5'h00, v[1], v[0], v[0]});
      end
      wr_reg(8'h23, 8'h00);
      bclk <= 1'b0;
      wr_reg(8'h24, 8'h04);
      wr_reg(8'h21, 8'h01);
      for (int r = 0; r < 4; r++) begin
         prev <= r[0] ^ r[1];
         wr_reg(8'h23, r[1] ? {5'h00, r[0], 2'h3} : 8'h01);
         bc_cycles(4);
         #1 check({6'h00, ph1, ph2}, {6'h00, r[0], !r[0]});
      end
      stop_test;
   end
   // Cuts a hang short well after the expected run of about 1100 cycles
   initial begin
      #100000;
      n_mismatch++;
      stop_test;
   end
endmodule // mdb_block_tb_top
`default_nettype wire
